/* core/dcts_pkg.sv */
package dcts_pkg;

   // ****************************************
   // clock and time base
   // ****************************************
   localparam int CLK_HZ          = 100_000_000;
   localparam int CLK_NS          = 10;

   // ****************************************
   // ping low-time windows on the receive pin
   // ****************************************
   localparam int RESUME_MIN_US   = 250;
   localparam int RESUME_MAX_US   = 300;
   localparam int WAKE_MIN_US     = 2000;
   localparam int WAKE_MAX_US     = 2500;
   localparam int SHDN_MIN_US     = 7000;
   localparam int SHDN_MAX_US     = 10000;
   localparam int HRST_MIN_US     = 36000;
   localparam int US_CYC          = (1000 + CLK_NS - 1) / CLK_NS;
   localparam int RESUME_MIN_CYC  = RESUME_MIN_US * US_CYC;
   localparam int RESUME_MAX_CYC  = RESUME_MAX_US * US_CYC;
   localparam int WAKE_MIN_CYC    = WAKE_MIN_US * US_CYC;
   localparam int WAKE_MAX_CYC    = WAKE_MAX_US * US_CYC;
   localparam int SHDN_MIN_CYC    = SHDN_MIN_US * US_CYC;
   localparam int SHDN_MAX_CYC    = SHDN_MAX_US * US_CYC;
   localparam int HRST_MIN_CYC    = HRST_MIN_US * US_CYC;

   // ****************************************
   // pulse timing of tones
   // ****************************************
   localparam int PULSE_HI_NS     = 1000;
   localparam int PULSE_HI_CYC    = PULSE_HI_NS / CLK_NS;
   localparam int CMD_SPACE_NS    = 11000;
   localparam int CMD_SPACE_CYC   = CMD_SPACE_NS / CLK_NS;
   localparam int FLT_SPACE_NS    = 11500;
   localparam int FLT_SPACE_CYC   = FLT_SPACE_NS / CLK_NS;
   localparam int GAP_MAX_NS      = 15000;
   localparam int GAP_MAX_CYC     = GAP_MAX_NS / CLK_NS;

   // ****************************************
   // pulse counts
   // ****************************************
   localparam int N_WAKE_DET      = 60;
   localparam int N_WAKE_TX       = 90;
   localparam int N_SHDN_DET      = 180;
   localparam int N_SHDN_TX       = 270;
   localparam int N_RESUME_DET    = 20;
   localparam int N_RESUME_TX     = 30;
   localparam int N_HRST_DET      = 540;
   localparam int N_HRST_TX       = 810;
   localparam int N_HB_DET        = 20;
   localparam int N_HB_TX         = 30;
   localparam int N_FLT_DET       = 60;
   localparam int N_FLT_TX        = 90;

   // ****************************************
   // long periods and latencies
   // ****************************************
   localparam int HB_PERIOD_MS    = 400;
   localparam int HB_TIMEOUT_MS   = 1000;
   localparam int HB_FAST_MS      = 200;
   localparam int FLT_PERIOD_MS   = 50;
   localparam int MS_CYC          = 1000 * US_CYC;
   localparam int HB_PERIOD_CYC   = HB_PERIOD_MS * MS_CYC;
   localparam int HB_TIMEOUT_CYC  = HB_TIMEOUT_MS * MS_CYC;
   localparam int HB_FAST_CYC     = HB_FAST_MS * MS_CYC;
   localparam int FLT_PERIOD_CYC  = FLT_PERIOD_MS * MS_CYC;
   localparam int FTS_LAT_US      = 48;
   localparam int FTB_LAT_US      = 24;
   localparam int FTS_LAT_CYC     = FTS_LAT_US * US_CYC;
   localparam int FTB_LAT_CYC     = FTB_LAT_US * US_CYC;
   localparam int SLP_ENTRY_US    = 100;
   localparam int SLP_ENTRY_CYC   = SLP_ENTRY_US * US_CYC / 2;
   localparam int SHDN_ENTRY_MS   = 20;
   localparam int SHDN_ENTRY_CYC  = SHDN_ENTRY_MS * MS_CYC;
   localparam int HRST_HOLD_MS    = 75;
   localparam int HRST_HOLD_CYC   = HRST_HOLD_MS * MS_CYC * 4 / 5;
   localparam int WAKE_FWD_US     = 1000;
   localparam int WAKE_FWD_CYC    = WAKE_FWD_US * US_CYC / 2;

   typedef enum logic [2:0] {
      DCTS_T_NONE, DCTS_T_RESUME, DCTS_T_WAKE, DCTS_T_SHDN, DCTS_T_HRST,
      DCTS_T_HB, DCTS_T_FLT
   } dcts_tone_t;

   typedef enum logic [2:0] {
      DCTS_S_ACTIVE, DCTS_S_SLEEP, DCTS_S_SLP_ENTRY, DCTS_S_SHDN_ENTRY,
      DCTS_S_SHDN, DCTS_S_HRST
   } dcts_state_t;

endpackage

/* core/dcts_tx_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dcts_tx_if;
   import dcts_pkg::*;
   logic        start;
   logic [9:0]  count;
   logic        slow;
   logic        busy;
   logic        pulse;
   modport ctrl (output start, output count, output slow, input busy, input pulse);
   modport gen  (input start, input count, input slow, output busy, output pulse);
endinterface
`default_nettype wire

/* core/dcts_tone_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// burst of high/low pulses on one port
// ****************************************
module dcts_tone_gen
   import dcts_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // control
   dcts_tx_if.gen    tx
);
   logic [9:0]  left;
   logic [11:0] phase;
   logic        slow_q;
   logic [11:0] space;
   logic        wrap;

   assign space = slow_q ? 12'(FLT_SPACE_CYC) : 12'(CMD_SPACE_CYC);
   assign wrap  = (phase == space - 12'h001);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         left     <= 10'h000;
         phase    <= 12'h000;
         slow_q   <= 1'b0;
         tx.busy  <= 1'b0;
         tx.pulse <= 1'b0;
      end else if (!tx.busy) begin
         tx.pulse <= 1'b0;
         if (tx.start && tx.count != 10'h000) begin
            left    <= tx.count;
            slow_q  <= tx.slow;
            phase   <= 12'h000;
            tx.busy <= 1'b1;
         end
      end else begin
         phase    <= wrap ? 12'h000 : phase + 12'h001;
         tx.pulse <= (phase < 12'(PULSE_HI_CYC));
         if (wrap) begin
            left <= left - 10'h001;
            if (left == 10'h001) begin
               tx.busy <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* core/dcts_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dcts_top
   import dcts_pkg::*;
#(
   parameter int HB_PERIOD   = HB_PERIOD_CYC,
   parameter int HB_TIMEOUT  = HB_TIMEOUT_CYC,
   parameter int HB_FAST     = HB_FAST_CYC,
   parameter int FLT_PERIOD  = FLT_PERIOD_CYC,
   parameter int SHDN_ENTRY  = SHDN_ENTRY_CYC,
   parameter int HRST_HOLD   = HRST_HOLD_CYC,
   parameter int PING_SCALE  = 1
)
(
   // clock and reset
   input  wire logic  clk_sys,
   input  wire logic  rst_n,
   // configuration
   input  wire logic  base_dev,
   input  wire logic  hb_enable,
   input  wire logic  sleep_req,
   input  wire logic  shdn_req,
   input  wire logic  fault_local,
   // host receive pin
   input  wire logic  rx_pin,
   // daisy chain tone receivers
   input  wire logic  north_port_rx,
   input  wire logic  south_port_rx,
   // daisy chain tone transmitters
   output logic       north_port_tx,
   output logic       south_port_tx,
   // fault output, open drain
   output logic       fault_out_n,
   output logic       fault_out_n_oe,
   // status
   output dcts_state_t power_state,
   output logic       hb_missing,
   output logic       hb_too_fast,
   output logic       fault_active,
   output logic       hard_reset
);
   // ****************************************
   // ping measurement
   // ****************************************
   logic [22:0] low_cnt;
   logic        rx_q;
   logic        ping_end;
   logic        p_resume;
   logic        p_wake;
   logic        p_shdn;
   logic        p_hrst;
   logic [22:0] lo_cyc;

   assign lo_cyc   = 23'(low_cnt) * 23'(PING_SCALE);
   assign ping_end = rx_pin && !rx_q;
   assign p_resume = ping_end && lo_cyc >= 23'(RESUME_MIN_CYC) && lo_cyc <= 23'(RESUME_MAX_CYC);
   assign p_wake   = ping_end && lo_cyc >= 23'(WAKE_MIN_CYC) && lo_cyc <= 23'(WAKE_MAX_CYC);
   assign p_shdn   = ping_end && lo_cyc >= 23'(SHDN_MIN_CYC) && lo_cyc <= 23'(SHDN_MAX_CYC);
   assign p_hrst   = ping_end && lo_cyc >= 23'(HRST_MIN_CYC);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_q    <= 1'b1;
         low_cnt <= 23'h000000;
      end else begin
         rx_q <= rx_pin;
         if (rx_pin) begin
            low_cnt <= 23'h000000;
         end else if (low_cnt != 23'h7FFFFF) begin
            low_cnt <= low_cnt + 23'h000001;
         end
      end
   end

   // ****************************************
   // tone receivers, one per port
   // ****************************************
   logic [1:0]  rx_in;
   logic [1:0]  rx_d;
   logic [9:0]  pcnt [2];
   logic [11:0] gap  [2];
   logic [1:0]  tone_end;
   dcts_tone_t  tone_cls [2];
   logic [1:0]  flt_det;

   assign rx_in = {north_port_rx, south_port_rx};

   for (genvar i = 0; i < 2; i++) begin : g_rx
      assign tone_end[i] = (pcnt[i] != 10'h000) && (gap[i] == 12'(GAP_MAX_CYC));
      assign tone_cls[i] = pcnt[i] >= 10'(N_HRST_DET)   ? DCTS_T_HRST   :
                           pcnt[i] >= 10'(N_SHDN_DET)   ? DCTS_T_SHDN   :
                           pcnt[i] >= 10'(N_WAKE_DET)   ? DCTS_T_WAKE   :
                           pcnt[i] >= 10'(N_RESUME_DET) ? DCTS_T_RESUME : DCTS_T_NONE;
      // fault tone is valid once 60 pulses are seen
      assign flt_det[i]  = rx_in[i] && !rx_d[i] && pcnt[i] == 10'(N_FLT_DET - 1);

      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            rx_d[i] <= 1'b0;
            pcnt[i] <= 10'h000;
            gap[i]  <= 12'h000;
         end else begin
            rx_d[i] <= rx_in[i];
            if (rx_in[i] && !rx_d[i]) begin
               pcnt[i] <= (pcnt[i] == 10'h3FF) ? pcnt[i] : pcnt[i] + 10'h001;
               gap[i]  <= 12'h000;
            end else if (tone_end[i]) begin
               pcnt[i] <= 10'h000;
               gap[i]  <= 12'h000;
            end else if (pcnt[i] != 10'h000) begin
               gap[i]  <= gap[i] + 12'h001;
            end
         end
      end
   end

   // tones from either port travel up on north; north wins when both ports end together
   dcts_tone_t  cmd_in;
   logic        cmd_end;
   assign cmd_end = tone_end[0] && !tone_end[1] ? 1'b1 : tone_end[1];
   assign cmd_in  = tone_end[1] ? tone_cls[1] : (tone_end[0] ? tone_cls[0] : DCTS_T_NONE);

   // ****************************************
   // tone generators
   // ****************************************
   dcts_tx_if tx_n ();
   dcts_tx_if tx_s ();

   dcts_tone_gen u_gen_n (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tx      (tx_n.gen)
   );
   dcts_tone_gen u_gen_s (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tx      (tx_s.gen)
   );

   // ****************************************
   // power state machine
   // ****************************************
   dcts_state_t state;
   dcts_state_t next_state;
   logic [22:0] st_cnt;
   logic        ev_resume;
   logic        ev_wake;
   logic        ev_shdn;
   logic        ev_hrst;
   logic        fwd_pend;
   logic [9:0]  fwd_count;

   assign ev_resume = p_resume || (cmd_end && cmd_in == DCTS_T_RESUME);
   assign ev_wake   = p_wake   || (cmd_end && cmd_in == DCTS_T_WAKE);
   assign ev_shdn   = p_shdn   || (cmd_end && cmd_in == DCTS_T_SHDN) || shdn_req;
   assign ev_hrst   = p_hrst   || (cmd_end && cmd_in == DCTS_T_HRST);

   always_comb begin
      next_state = state;
      unique case (state)
         DCTS_S_ACTIVE: begin
            if (ev_hrst) begin
               next_state = DCTS_S_HRST;
            end else if (ev_shdn) begin
               next_state = DCTS_S_SHDN_ENTRY;
            end else if (sleep_req) begin
               next_state = DCTS_S_SLP_ENTRY;
            end
         end
         DCTS_S_SLP_ENTRY: begin
            if (st_cnt == 23'(SLP_ENTRY_CYC)) begin
               next_state = DCTS_S_SLEEP;
            end
         end
         DCTS_S_SLEEP: begin
            if (ev_hrst) begin
               next_state = DCTS_S_HRST;
            end else if (ev_shdn) begin
               next_state = DCTS_S_SHDN_ENTRY;
            end else if (ev_resume || ev_wake) begin
               next_state = DCTS_S_ACTIVE;
            end
         end
         DCTS_S_SHDN_ENTRY: begin
            if (st_cnt == 23'(SHDN_ENTRY)) begin
               next_state = DCTS_S_SHDN;
            end
         end
         DCTS_S_SHDN: begin
            if (ev_hrst) begin
               next_state = DCTS_S_HRST;
            end else if (ev_wake) begin
               next_state = DCTS_S_ACTIVE;
            end
         end
         DCTS_S_HRST: begin
            if (st_cnt == 23'(HRST_HOLD)) begin
               next_state = DCTS_S_SHDN;
            end
         end
         default: next_state = DCTS_S_ACTIVE;
      endcase
   end

   // forward length of the received command tone
   logic [9:0] cmd_len;
   assign cmd_len = ev_hrst ? 10'(N_HRST_TX) : ev_shdn ? 10'(N_SHDN_TX) :
                    ev_wake ? 10'(N_WAKE_TX) : 10'(N_RESUME_TX);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state     <= DCTS_S_ACTIVE;
         st_cnt    <= 23'h000000;
         fwd_pend  <= 1'b0;
         fwd_count <= 10'h000;
      end else begin
         state  <= next_state;
         st_cnt <= (next_state != state) ? 23'h000000 : st_cnt + 23'h000001;
         if (ev_hrst || (ev_shdn && !shdn_req) || ((ev_wake || ev_resume)
             && state inside {DCTS_S_SLEEP, DCTS_S_SHDN})) begin
            fwd_pend  <= 1'b1;
            fwd_count <= cmd_len;
         end else if (tx_n.start) begin
            fwd_pend  <= 1'b0;
         end
      end
   end

   // ****************************************
   // heartbeat
   // ****************************************
   logic [26:0] hb_tx_cnt;
   logic [26:0] hb_rx_cnt;
   logic        hb_seen;
   logic        hb_go;
   logic        hb_rx;
   logic        running;

   assign running = (state == DCTS_S_ACTIVE) || (state == DCTS_S_SLEEP);
   assign hb_go   = running && hb_enable && hb_tx_cnt == 27'(HB_PERIOD - 1);
   // heartbeat comes up from below: counted on south port
   assign hb_rx   = rx_in[0] && !rx_d[0] && pcnt[0] == 10'(N_HB_DET - 1)
                    && hb_enable && !base_dev;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hb_tx_cnt   <= 27'h0000000;
         hb_rx_cnt   <= 27'h0000000;
         hb_seen     <= 1'b0;
         hb_missing  <= 1'b0;
         hb_too_fast <= 1'b0;
      end else begin
         hb_tx_cnt <= hb_go || !hb_enable ? 27'h0000000 : hb_tx_cnt + 27'h0000001;
         if (hb_rx) begin
            hb_too_fast <= hb_seen && hb_rx_cnt < 27'(HB_FAST);
            hb_rx_cnt   <= 27'h0000000;
            hb_seen     <= 1'b1;
            hb_missing  <= 1'b0;
         end else if (hb_enable && !base_dev && running) begin
            if (hb_rx_cnt == 27'(HB_TIMEOUT)) begin
               hb_missing <= 1'b1;
            end else begin
               hb_rx_cnt  <= hb_rx_cnt + 27'h0000001;
            end
         end
      end
   end

   // ****************************************
   // fault tones
   // ****************************************
   logic        flt_rx;
   logic        flt_relay;
   logic [12:0] lat_cnt;
   logic        lat_run;
   logic [22:0] flt_cnt;
   logic        flt_go;

   assign flt_rx  = flt_det[0];
   assign flt_go  = fault_active && !base_dev && flt_cnt == 23'(FLT_PERIOD - 1);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lat_run      <= 1'b0;
         lat_cnt      <= 13'h0000;
         flt_relay    <= 1'b0;
         flt_cnt      <= 23'h000000;
         fault_active <= 1'b0;
      end else begin
         if (flt_rx && !lat_run) begin
            lat_run <= 1'b1;
            lat_cnt <= 13'h0000;
         end else if (lat_run) begin
            lat_cnt <= lat_cnt + 13'h0001;
            if (lat_cnt == (base_dev ? 13'(FTB_LAT_CYC) : 13'(FTS_LAT_CYC))) begin
               lat_run   <= 1'b0;
               flt_relay <= 1'b1;
            end
         end
         fault_active <= fault_local || flt_relay;
         flt_cnt <= !fault_active || flt_go ? 23'h000000 : flt_cnt + 23'h000001;
      end
   end

   // ****************************************
   // generator control and outputs
   // ****************************************
   logic fire_flt;
   assign fire_flt = fault_active && !base_dev && (flt_cnt == 23'h000000) && !tx_s.busy;

   // commands go north on the command time base
   assign tx_n.start = fwd_pend && !tx_n.busy;
   assign tx_n.count = fwd_count;
   assign tx_n.slow  = 1'b0;
   // fault and heartbeat go south on the slow time base
   assign tx_s.start = fire_flt || (hb_go && !tx_s.busy);
   assign tx_s.count = fire_flt ? 10'(N_FLT_TX) : 10'(N_HB_TX);
   assign tx_s.slow  = 1'b1;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         north_port_tx  <= 1'b0;
         south_port_tx  <= 1'b0;
         fault_out_n    <= 1'b0;
         fault_out_n_oe <= 1'b1;
         power_state    <= DCTS_S_ACTIVE;
         hard_reset     <= 1'b0;
      end else begin
         north_port_tx  <= tx_n.pulse;
         south_port_tx  <= tx_s.pulse;
         fault_out_n    <= 1'b0;
         fault_out_n_oe <= !(base_dev && fault_active);
         power_state    <= state;
         hard_reset     <= (state == DCTS_S_HRST);
      end
   end
endmodule
`default_nettype wire

/* dv/dcts_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module dcts_top_chk
   import dcts_pkg::*;
#(
   parameter int HB_TIMEOUT = HB_TIMEOUT_CYC,
   parameter int HRST_HOLD  = HRST_HOLD_CYC
)
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_n,
   // watched ports
   input wire logic        base_dev,
   input wire logic        south_port_rx,
   input wire logic        north_port_tx,
   input wire logic        south_port_tx,
   input wire logic        fault_out_n_oe,
   input wire dcts_state_t power_state,
   input wire logic        hb_missing,
   input wire logic        hard_reset
);
   // ****************************************
   // pulse, tone and state timers
   // ****************************************
   logic [1:0]  tx;
   logic [1:0]  tq;
   logic [31:0] hi_n [2];
   logic [31:0] per_n [2];
   logic        rq;
   logic        rx_rise;
   logic [31:0] sr_n;
   logic [31:0] f_n;
   logic [31:0] st_n;
   logic [9:0]  e_n;
   dcts_state_t sq;

   assign tx      = {south_port_tx, north_port_tx};
   assign rx_rise = south_port_rx & ~rq;

   function automatic logic [31:0] sat(input logic [31:0] v);
      return (v == 32'hFFFFFFFF) ? v : v + 32'h1;
   endfunction

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tq    <= 2'h0;
         rq    <= 1'b0;
         hi_n  <= '{2{32'h0}};
         per_n <= '{2{32'hFFFFFFFF}};
         sr_n  <= 32'h0;
         f_n   <= 32'hFFFFFFFF;
         st_n  <= 32'h0;
         e_n   <= 10'h0;
         sq    <= DCTS_S_ACTIVE;
      end else begin
         tq <= tx;
         rq <= south_port_rx;
         sq <= power_state;
         for (int k = 0; k < 2; k++) begin
            hi_n[k]  <= tx[k] ? hi_n[k] + 32'h1 : 32'h0;
            per_n[k] <= (tx[k] & ~tq[k]) ? 32'h1 : sat(per_n[k]);
         end
         sr_n <= rx_rise ? 32'h0 : sat(sr_n);
         e_n  <= rx_rise ? e_n + 10'h1 : (sr_n > 32'd1500 ? 10'h0 : e_n);
         f_n  <= (rx_rise && e_n == 10'd59) ? 32'h1 : sat(f_n);
         st_n <= (power_state != sq) ? 32'h1 : sat(st_n);
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_north_pulse_high: assert property ($fell(north_port_tx) |-> hi_n[0] == PULSE_HI_CYC)
      else $error("north pulse high time wrong");
   chk_south_pulse_high: assert property ($fell(south_port_tx) |-> hi_n[1] == PULSE_HI_CYC)
      else $error("south pulse high time wrong");
   chk_north_pulse_space: assert property ($rose(north_port_tx) |->
      per_n[0] == CMD_SPACE_CYC || per_n[0] > GAP_MAX_CYC)
      else $error("north pulse spacing wrong");
   chk_south_pulse_space: assert property ($rose(south_port_tx) |->
      per_n[1] == FLT_SPACE_CYC || per_n[1] > GAP_MAX_CYC)
      else $error("south pulse spacing wrong");
   chk_sleep_entry_time: assert property (power_state == DCTS_S_SLP_ENTRY && sq == DCTS_S_SLP_ENTRY |->
      st_n < SLP_ENTRY_US * US_CYC)
      else $error("sleep entry too long");
   chk_hrst_hold_time: assert property (power_state == DCTS_S_HRST && sq == DCTS_S_HRST |->
      st_n <= HRST_HOLD + 2)
      else $error("hard reset held too long");
   chk_hrst_then_shdn: assert property ($fell(power_state == DCTS_S_HRST) |-> power_state == DCTS_S_SHDN)
      else $error("hard reset not left to shutdown");
   chk_hrst_flag_state: assert property ($rose(hard_reset) |-> ##[0:2] power_state == DCTS_S_HRST)
      else $error("hard reset flag without state");
   chk_base_fault_lat: assert property ($fell(fault_out_n_oe) |->
      base_dev && f_n >= FTB_LAT_CYC && f_n <= FTB_LAT_CYC + 8)
      else $error("fault output latency wrong");
   chk_hb_missing_time: assert property ($rose(hb_missing) |-> sr_n >= HB_TIMEOUT - 4)
      else $error("heartbeat missing too early");

   cover property ($fell(fault_out_n_oe));
   cover property ($rose(hard_reset));
   cover property (power_state == DCTS_S_SLEEP && sq == DCTS_S_SLP_ENTRY);
endmodule

bind dcts_top dcts_top_chk #(
   .HB_TIMEOUT(HB_TIMEOUT),
   .HRST_HOLD (HRST_HOLD)
) i_dcts_top_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .base_dev(base_dev), .south_port_rx(south_port_rx),
   .north_port_tx(north_port_tx), .south_port_tx(south_port_tx), .fault_out_n_oe(fault_out_n_oe),
   .power_state(power_state), .hb_missing(hb_missing), .hard_reset(hard_reset)
);
`default_nettype wire

/* dv/dcts_nbr_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcts_nbr_model
   import dcts_pkg::*;
(
   // clock
   input  wire logic clk_sys,
   // tone line, low between pulses
   output logic      line
);
   initial line = 1'b0;

   // n pulses of 1 us high, starts per cycles apart
   task automatic send(input int n, input int per);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         line <= 1'b1;
         repeat (PULSE_HI_CYC) @(posedge clk_sys);
         line <= 1'b0;
         repeat (per - PULSE_HI_CYC - 1) @(posedge clk_sys);
      end
   endtask
endmodule
`default_nettype wire

/* dv/daisy_chain_tone_signalling_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_tone_signalling_tb
   import dcts_pkg::*;
;
   localparam int PSC = 200;
   logic        clk_sys     = 1'b0;
   logic        rst_n       = 1'b0;
   logic        base_dev    = 1'b0;
   logic        hb_enable   = 1'b0;
   logic        sleep_req   = 1'b0;
   logic        shdn_req    = 1'b0;
   logic        fault_local = 1'b0;
   logic        rx_pin      = 1'b1;
   logic        north_port_rx, south_port_rx, north_port_tx, south_port_tx;
   logic        fault_out_n, fault_out_n_oe, hb_missing, hb_too_fast, fault_active, hard_reset;
   dcts_state_t power_state;
   int          err_total = 0;
   int          n_checks  = 0;
   int          cyc       = 0;
   int          n;
   int unsigned seed      = 85;

   always #5 clk_sys = ~clk_sys;

   dcts_top #(.HB_PERIOD(40000), .HB_TIMEOUT(5000), .FLT_PERIOD(3000),
      .SHDN_ENTRY(500), .HRST_HOLD(500), .PING_SCALE(PSC)) i_dcts_top (
      .clk_sys(clk_sys), .rst_n(rst_n), .base_dev(base_dev), .hb_enable(hb_enable),
      .sleep_req(sleep_req), .shdn_req(shdn_req), .fault_local(fault_local), .rx_pin(rx_pin),
      .north_port_rx(north_port_rx), .south_port_rx(south_port_rx), .north_port_tx(north_port_tx),
      .south_port_tx(south_port_tx), .fault_out_n(fault_out_n), .fault_out_n_oe(fault_out_n_oe),
      .power_state(power_state), .hb_missing(hb_missing), .hb_too_fast(hb_too_fast),
      .fault_active(fault_active), .hard_reset(hard_reset));
   dcts_nbr_model i_dcts_nbr_model_n (.clk_sys(clk_sys), .line(north_port_rx));
   dcts_nbr_model i_dcts_nbr_model_s (.clk_sys(clk_sys), .line(south_port_rx));

   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // ping low time in cycles, inside a window
   function automatic int win(input int lo, input int hi);
      return (lo + int'(rnd() % (hi - lo + 1))) / PSC;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic rst_dut();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      base_dev <= 1'b0;
      hb_enable <= 1'b0;
      fault_local <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
   endtask
   task automatic ping(input int lo);
      @(posedge clk_sys);
      rx_pin <= 1'b0;
      repeat (lo) @(posedge clk_sys);
      rx_pin <= 1'b1;
      @(negedge clk_sys);
   endtask
   task automatic wait_st(input dcts_state_t st, input int max);
      for (int i = 0; i < max && power_state !== st; i++) @(negedge clk_sys);
      chk("power_state", 32'(power_state), 32'(st));
   endtask
   task automatic wait_hi(input bit sel, input int max);
      for (int i = 0; i < max && (sel ? south_port_tx : north_port_tx) !== 1'b1; i++) @(negedge clk_sys);
      chk("tx pulse", 32'(sel ? south_port_tx : north_port_tx), 32'h1);
   endtask
   task automatic count_n(input int w, output int c);
      logic q;
      c = 0;
      q = 1'b0;
      repeat (w) begin
         @(negedge clk_sys);
         if (north_port_tx === 1'b1 && q !== 1'b1) c++;
         q = north_port_tx;
      end
   endtask

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 105000) begin
         err_total++;
         report_and_stop();
      end
   end

   initial begin
      rst_dut();
      @(posedge clk_sys);
      hb_enable <= 1'b1;
      sleep_req <= 1'b1;
      wait_st(DCTS_S_SLEEP, 6000);
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      i_dcts_nbr_model_n.send(N_RESUME_DET, 200 + int'(rnd() % 31));
      count_n(1600 + N_RESUME_TX * CMD_SPACE_CYC, n);
      chk("resume pulses", 32'(n), 32'(N_RESUME_TX));
      chk("power_state", 32'(power_state), 32'(DCTS_S_ACTIVE));
      chk("hb_missing", 32'(hb_missing), 32'h1);
      rst_dut();
      @(posedge clk_sys);
      shdn_req <= 1'b1;
      wait_st(DCTS_S_SHDN, 520);
      @(posedge clk_sys);
      shdn_req <= 1'b0;
      ping(win(WAKE_MIN_CYC, WAKE_MAX_CYC));
      wait_hi(1'b0, 20);
      wait_st(DCTS_S_ACTIVE, 5);
      ping(win(SHDN_MIN_CYC, SHDN_MAX_CYC));
      wait_st(DCTS_S_SHDN_ENTRY, 5);
      wait_st(DCTS_S_SHDN, 510);
      rst_dut();
      ping(WAKE_MAX_CYC / PSC + 2);
      ping(SHDN_MIN_CYC / PSC - 2);
      repeat (5) @(negedge clk_sys);
      chk("power_state", 32'(power_state), 32'(DCTS_S_ACTIVE));
      chk("north_port_tx", 32'(north_port_tx), 32'h0);
      ping(win(HRST_MIN_CYC, HRST_MIN_CYC + 20000));
      wait_st(DCTS_S_HRST, 5);
      chk("hard_reset", 32'(hard_reset), 32'h1);
      wait_st(DCTS_S_SHDN, 510);
      chk("hard_reset", 32'(hard_reset), 32'h0);
      rst_dut();
      @(posedge clk_sys);
      hb_enable <= 1'b1;
      sleep_req <= 1'b1;
      wait_st(DCTS_S_SLEEP, 6000);
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      ping(win(RESUME_MIN_CYC, RESUME_MAX_CYC));
      wait_st(DCTS_S_ACTIVE, 5);
      for (int k = 0; k < 2; k++) begin
         i_dcts_nbr_model_s.send(N_HB_DET, 110);
         repeat (2) @(negedge clk_sys);
         chk("hb_too_fast", 32'(hb_too_fast), 32'(k));
         repeat (GAP_MAX_CYC) @(negedge clk_sys);
      end
      rst_dut();
      @(posedge clk_sys);
      base_dev <= 1'b1;
      i_dcts_nbr_model_s.send(N_FLT_DET, 110);
      @(negedge clk_sys);
      chk("fault_out_n_oe", 32'(fault_out_n_oe), 32'h1);
      repeat (FTB_LAT_CYC) @(negedge clk_sys);
      chk("fault_out_n_oe", 32'(fault_out_n_oe), 32'h0);
      chk("fault_out_n", 32'(fault_out_n), 32'h0);
      @(posedge clk_sys);
      base_dev <= 1'b0;
      fault_local <= 1'b1;
      wait_hi(1'b1, 3100);
      chk("fault_active", 32'(fault_active), 32'h1);
      report_and_stop();
   end
endmodule
`default_nettype wire
